//--- verilog/rlg_pkg.sv
package rlg_pkg;

  // ==========================================================
  // Bus and register map
  // ==========================================================
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          RAIL_N      = 4;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_SHALLOW = 8'h04;
  localparam logic [7:0]  ADDR_DEEP   = 8'h08;
  localparam logic [7:0]  ADDR_CAUSE  = 8'h0c;
  localparam logic [7:0]  ADDR_EVENT  = 8'h10;
  localparam logic [7:0]  ADDR_MASK   = 8'h14;
  localparam logic [7:0]  ADDR_STATE  = 8'h18;
  localparam logic [7:0]  DEEP_KEY    = 8'h1b;
  localparam int          CTRL_WDT_EN = 4;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  // ==========================================================
  // Reset levels, thermometer coded
  // ==========================================================
  localparam int LVL_N       = 3;
  localparam int LVL_SYS     = 0;
  localparam int LVL_SHALLOW = 1;
  localparam int LVL_DEEP    = 2;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEBOUNCE_NS   = 1000;
  localparam int HOLD_NS       = 2000;
  localparam int DB_CYC_I   = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC_I = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DB_LAST   = 8'(DB_CYC_I - 1);
  localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC_I - 1);

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    RLG_RUN   = 3'h1,
    RLG_HOLD  = 3'h2,
    RLG_DRAIN = 3'h4
  } rlg_state_e;

  // Reset causes and event flags share one layout
  typedef struct packed {
    logic wdt_irq;
    logic pin;
    logic wdt;
    logic deep;
    logic shallow;
    logic core;
    logic rail;
    logic supply;
  } rlg_cause_s;

endpackage : rlg_pkg

//--- verilog/rlg_top.sv
// Behaviour
// - Supply low always resets, not configurable
// - Each rail brown-out resets only when enabled
// - Rail brown-out resets and pulls pin low
// - Brown-out leaves its event flag set
// - Clock and RTC registers held during brown-out
// - RTC and timer keep counting, RC when low
// - Core reset request always resets, unmaskable
// - Shallow write resets all but retained blocks
// - Shallow reset forces processor clock to 96 MHz
// - Deep reset only on exact key write
// - Deep reset reloads settings, resets all blocks
// - Deep reset reloads RTC source select trim
// - Deep reset clears clock generator state
// - Watchdog expiry raises an interrupt
// - Watchdog resets only when its enable allows
// - Every reset records its cause
// - Low reset pin always resets, except while it is low from our own pull-down
// - Reset pin input is debounced
//
// Chosen here: the plain strobed port and the placing of the registers.
module rlg_top (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic        supply_low,
  input  wire logic [3:0]  rail_low,
  input  wire logic        core_reset_req,
  input  wire logic        wdt_expire,
  input  wire logic        power_down,
  input  wire logic        reset_pin_n_in,
  output logic      [31:0] rdata,
  output logic             irq,
  output logic             system_reset_n,
  output logic             shallow_reset_n,
  output logic             deep_digital_reset_n,
  output logic             cpu_clk_96_sel,
  output logic             reload_settings,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_b,
  output logic             retain_hold,
  output logic             rtc_on_rc_osc
);

  // ==========================================================
  // Reset synchroniser
  // ==========================================================
  logic rst_meta;
  logic rst_sync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= '0;
      rst_sync_b <= '0;
    end else begin
      rst_meta   <= '1;
      rst_sync_b <= rst_meta;
    end
  end

  // ==========================================================
  // Registers and decode
  // ==========================================================
  logic [3:0]           rail_en;
  logic                 wdt_rst_en;
  rlg_pkg::rlg_cause_s  cause;
  rlg_pkg::rlg_cause_s  events;
  rlg_pkg::rlg_cause_s  mask;
  rlg_pkg::rlg_state_e  state;
  rlg_pkg::rlg_state_e  next_state;
  logic [2:0]           lvl;
  logic [31:0]          rd_mux;

  wire wr_ctrl    = wr_stb && (addr == rlg_pkg::ADDR_CTRL);
  wire wr_shallow = wr_stb && (addr == rlg_pkg::ADDR_SHALLOW);
  wire wr_deep    = wr_stb && (addr == rlg_pkg::ADDR_DEEP);
  wire wr_event   = wr_stb && (addr == rlg_pkg::ADDR_EVENT);
  wire wr_mask    = wr_stb && (addr == rlg_pkg::ADDR_MASK);
  wire deep_hit   = wr_deep && (wdata[7:0] == rlg_pkg::DEEP_KEY);

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rail_en    <= '0;
      wdt_rst_en <= '0;
      mask       <= '0;
    end else begin
      if (wr_ctrl) begin
        rail_en    <= wdata[rlg_pkg::RAIL_N-1:0];
        wdt_rst_en <= wdata[rlg_pkg::CTRL_WDT_EN];
      end
      if (wr_mask) begin
        mask <= wdata[7:0];
      end
    end
  end

  always_comb begin
    if (addr == rlg_pkg::ADDR_CTRL) begin
      rd_mux = {27'h000_0000, wdt_rst_en, rail_en};
    end else if (addr == rlg_pkg::ADDR_CAUSE) begin
      rd_mux = {24'h00_0000, cause};
    end else if (addr == rlg_pkg::ADDR_EVENT) begin
      rd_mux = {24'h00_0000, events};
    end else if (addr == rlg_pkg::ADDR_MASK) begin
      rd_mux = {24'h00_0000, mask};
    end else if (addr == rlg_pkg::ADDR_STATE) begin
      rd_mux = {24'h00_0000, state, lvl, retain_hold, rtc_on_rc_osc};
    end else begin
      rd_mux = rlg_pkg::READ_ZERO;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata <= '0;
    end else begin
      rdata <= rd_stb ? rd_mux : rlg_pkg::READ_ZERO;
    end
  end

  // ==========================================================
  // Reset pin debounce
  // ==========================================================
  logic       pin_db;
  logic [7:0] db_cnt;
  logic       pin_self;

  wire pin_diff = reset_pin_n_in != pin_db;
  wire db_done  = pin_diff && (db_cnt == rlg_pkg::DB_LAST);

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_db   <= '1;
      db_cnt   <= '0;
      pin_self <= '0;
    end else begin
      db_cnt   <= (pin_diff && !db_done) ? db_cnt + 8'h01 : 8'h00;
      pin_db   <= db_done ? reset_pin_n_in : pin_db;
      pin_self <= !reset_pin_oe_b || (pin_self && !pin_db);
    end
  end

  // Our own pull-down must not retrigger a pin reset
  wire pin_req = !pin_db && !pin_self;

  // ==========================================================
  // Request gathering
  // ==========================================================
  logic [3:0] rail_hit;
  logic       sh_pend;
  logic       dp_pend;
  logic       core_pend;
  logic       wdt_pend;

  for (genvar i = 0; i < rlg_pkg::RAIL_N; i++) begin : g_rail
    assign rail_hit[i] = rail_low[i] && rail_en[i];
  end

  wire rail_req = |rail_hit;
  wire wdt_req  = wdt_expire && wdt_rst_en;
  wire in_hold  = state == rlg_pkg::RLG_HOLD;

  rlg_pkg::rlg_cause_s req_now;
  assign req_now = '{
    wdt_irq: 1'b0,
    pin:     pin_req,
    wdt:     wdt_req || wdt_pend,
    deep:    deep_hit || dp_pend,
    shallow: wr_shallow || sh_pend,
    core:    core_reset_req || core_pend,
    rail:    rail_req,
    supply:  supply_low
  };

  wire any_req = |req_now;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sh_pend   <= '0;
      dp_pend   <= '0;
      core_pend <= '0;
      wdt_pend  <= '0;
    end else begin
      sh_pend   <= wr_shallow || (sh_pend && !in_hold);
      dp_pend   <= deep_hit || (dp_pend && !in_hold);
      core_pend <= core_reset_req || (core_pend && !in_hold);
      wdt_pend  <= wdt_req || (wdt_pend && !in_hold);
    end
  end

  wire [2:0] lvl_now = {req_now.deep,
                        req_now.supply || req_now.rail || req_now.shallow
                        || req_now.deep || req_now.wdt || req_now.pin,
                        any_req};

  // ==========================================================
  // Sequencer
  // ==========================================================
  logic [7:0]          drain_cnt;
  logic [2:0]          next_lvl;
  rlg_pkg::rlg_cause_s next_cause;

  wire drain_end = drain_cnt == rlg_pkg::HOLD_LAST;

  always_comb begin
    case (state)
      rlg_pkg::RLG_RUN: begin
        next_state = any_req ? rlg_pkg::RLG_HOLD : rlg_pkg::RLG_RUN;
      end
      rlg_pkg::RLG_HOLD: begin
        next_state = any_req ? rlg_pkg::RLG_HOLD : rlg_pkg::RLG_DRAIN;
      end
      rlg_pkg::RLG_DRAIN: begin
        if (any_req) begin
          next_state = rlg_pkg::RLG_HOLD;
        end else if (drain_end) begin
          next_state = rlg_pkg::RLG_RUN;
        end else begin
          next_state = rlg_pkg::RLG_DRAIN;
        end
      end
      default: begin
        next_state = rlg_pkg::RLG_RUN;
      end
    endcase
  end

  wire running  = state == rlg_pkg::RLG_RUN;
  wire releases = (state == rlg_pkg::RLG_DRAIN) && !any_req && drain_end;
  wire active   = next_state != rlg_pkg::RLG_RUN;

  assign next_lvl = running ? lvl_now : (lvl | lvl_now);

  assign next_cause = (running && any_req) ? req_now
                    : (running ? cause : (cause | req_now));

  wire next_pd = active && (!reset_pin_oe_b || supply_low || rail_req);

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state     <= rlg_pkg::RLG_RUN;
      lvl       <= '0;
      cause     <= '0;
      drain_cnt <= '0;
    end else begin
      state     <= next_state;
      lvl       <= next_lvl;
      cause     <= next_cause;
      drain_cnt <= (state == rlg_pkg::RLG_DRAIN && !any_req)
                   ? drain_cnt + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      system_reset_n       <= '0;
      shallow_reset_n      <= '0;
      deep_digital_reset_n <= '0;
      reset_pin_out        <= '0;
      reset_pin_oe_b       <= '1;
    end else begin
      system_reset_n       <= !active;
      shallow_reset_n      <= !(active && next_lvl[rlg_pkg::LVL_SHALLOW]);
      deep_digital_reset_n <= !(active && next_lvl[rlg_pkg::LVL_DEEP]);
      reset_pin_out        <= '0;
      reset_pin_oe_b       <= !next_pd;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cpu_clk_96_sel  <= '0;
      reload_settings <= '0;
    end else begin
      cpu_clk_96_sel  <= releases && lvl[rlg_pkg::LVL_SHALLOW];
      reload_settings <= releases && lvl[rlg_pkg::LVL_DEEP];
    end
  end

  // ==========================================================
  // Brown-out retention
  // ==========================================================
  // retention and RTC source
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      retain_hold   <= '0;
      rtc_on_rc_osc <= '0;
    end else begin
      retain_hold   <= supply_low || rail_req
                       || (retain_hold && !power_down);
      rtc_on_rc_osc <= supply_low;
    end
  end

  // ==========================================================
  // Event flags and interrupt
  // ==========================================================
  rlg_pkg::rlg_cause_s ev_set;
  rlg_pkg::rlg_cause_s ev_clr;
  rlg_pkg::rlg_cause_s next_events;

  assign ev_set      = req_now | {wdt_expire, 7'h00};
  assign ev_clr      = wr_event ? wdata[7:0] : 8'h00;
  assign next_events = (events & ~ev_clr) | ev_set;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      events <= '0;
      irq    <= '0;
    end else begin
      events <= next_events;
      irq    <= |(next_events & mask);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync_b);

  a_supply_reset: assert property (
    supply_low |=> !system_reset_n && !shallow_reset_n)
    else $error("supply low did not reset");

  a_rail_pulldown: assert property (
    rail_req |=> !system_reset_n && !reset_pin_oe_b)
    else $error("rail brown-out without reset and pull-down");

  a_rail_masked: assert property (
    running && !any_req && |rail_low |=> system_reset_n)
    else $error("reset without an enabled source");

  a_brownout_flag: assert property (
    supply_low |=> events.supply [*2])
    else $error("brown-out event flag missing");

  a_core_reset: assert property (
    core_reset_req |=> !system_reset_n)
    else $error("core request did not reset");

  a_shallow_level: assert property (
    wr_shallow |=> !shallow_reset_n && deep_digital_reset_n == !lvl[2])
    else $error("shallow write gave wrong depth");

  a_deep_key: assert property (
    $fell(deep_digital_reset_n) |-> $past(deep_hit || dp_pend))
    else $error("deep reset without key");

  a_deep_reload: assert property (
    reload_settings |-> system_reset_n && $past(state == rlg_pkg::RLG_DRAIN))
    else $error("reload outside deep release");

  a_wdt_irq: assert property (
    wdt_expire && mask.wdt_irq |=> irq && events.wdt_irq)
    else $error("watchdog interrupt missing");

  a_wdt_masked: assert property (
    wdt_expire && !wdt_rst_en && !wdt_pend |-> !req_now.wdt)
    else $error("masked watchdog raised a reset request");

  a_cause_kept: assert property (
    $rose(system_reset_n) |-> $past(running) || cause != 8'h00)
    else $error("reset released with no cause");

  a_pin_reset: assert property (
    pin_req |=> !system_reset_n)
    else $error("pin low did not reset");

  a_pin_debounce: assert property (
    $changed(pin_db) |-> $past(db_cnt) == rlg_pkg::DB_LAST)
    else $error("pin level taken before debounce");

  a_release_drain: assert property (
    $rose(system_reset_n) |-> $past(running || (drain_end && !any_req)))
    else $error("release before hold time");

endmodule : rlg_top

//--- sim/rlg_req_model.sv
module rlg_req_model (
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [2:0] op,
  input  wire logic [3:0] rail,
  input  wire logic [7:0] len,
  input  wire logic       reset_pin_out,
  input  wire logic       reset_pin_oe_b,
  output logic            supply_low,
  output logic [3:0]      rail_low,
  output logic            core_reset_req,
  output logic            wdt_expire,
  output logic            power_down,
  output logic            reset_pin_n_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left = 8'h00;
  logic [2:0] cur  = 3'h0;
  logic [3:0] sel  = 4'h0;
  logic       busy;

  // ==========================================================
  // Request lines, each held for the commanded cycle count
  always @(posedge clock) begin
    if (go) begin
      cur  <= op;
      sel  <= rail;
      left <= len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign busy           = (left != 8'h00);
  assign supply_low     = busy && (cur == 3'h0);
  assign rail_low       = (busy && (cur == 3'h1)) ? sel : 4'h0;
  assign core_reset_req = busy && (cur == 3'h2);
  assign wdt_expire     = busy && (cur == 3'h3);
  assign power_down     = busy && (cur == 3'h5);
  // Pad pull-up; the button or the device pull-down takes it low
  assign reset_pin_n_in = reset_pin_oe_b ? !(busy && (cur == 3'h4))
                                         : reset_pin_out;
endmodule : rlg_req_model

//--- sim/reset_level_generator_tb_top.sv
module reset_level_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] op;
    logic [3:0] rail;
    logic [4:0] ctrl;
    logic [7:0] wd;
    logic [7:0] len;
    logic [5:0] chk;
    logic [5:0] exp;
    logic [7:0] cause;
    logic [7:0] ev;
  } rlg_row_s;
  logic        clock, rst_b, wr_stb, rd_stb, go, mon_clr;
  logic        supply_low, core_reset_req, wdt_expire, power_down;
  logic        reset_pin_n_in, irq, system_reset_n, shallow_reset_n;
  logic        deep_digital_reset_n, cpu_clk_96_sel, reload_settings;
  logic        reset_pin_out, reset_pin_oe_b, retain_hold, rtc_on_rc_osc;
  logic [2:0]  op;
  logic [3:0]  rail, rail_low;
  logic [5:0]  seen;
  logic [7:0]  addr, len, lowcnt;
  logic [31:0] wdata, rdata, d;
  int          err_total, cmp_count;
  rlg_row_s    rows [0:16];

  rlg_top rlg_top_i (.clock, .rst_b, .addr, .wdata, .wr_stb, .rd_stb,
    .supply_low, .rail_low, .core_reset_req, .wdt_expire, .power_down,
    .reset_pin_n_in, .rdata, .irq, .system_reset_n, .shallow_reset_n,
    .deep_digital_reset_n, .cpu_clk_96_sel, .reload_settings,
    .reset_pin_out, .reset_pin_oe_b, .retain_hold, .rtc_on_rc_osc);
  rlg_req_model rlg_req_model_i (.clock, .go, .op, .rail, .len,
    .reset_pin_out, .reset_pin_oe_b, .supply_low, .rail_low,
    .core_reset_req, .wdt_expire, .power_down, .reset_pin_n_in);

  // ==========================================================
  // Clock and reset-output monitor
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (mon_clr) begin
      seen   <= 6'h00;
      lowcnt <= 8'h00;
    end else begin
      seen <= seen | {!system_reset_n, !shallow_reset_n,
        !deep_digital_reset_n, !reset_pin_oe_b, cpu_clk_96_sel,
        reload_settings};
      if (!system_reset_n) lowcnt <= lowcnt + 8'h01;
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    @(posedge clock);
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 v = rdata;
    @(posedge clock);
    #1 check(rdata, 32'h0000_0000);
    @(posedge clock);
  endtask : bus_rd
  task automatic start_op(input logic [2:0] o, input logic [3:0] s,
                          input logic [7:0] n);
    op   <= o;
    rail <= s;
    len  <= n;
    go   <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : start_op
  task automatic wait_rel(input int n);
    repeat (n) @(posedge clock);
    for (int i = 0; i < 300 && system_reset_n !== 1'b1; i++)
      @(posedge clock);
    @(posedge clock);
    check(32'(system_reset_n), 32'h1);
  endtask : wait_rel
  task automatic clr_mon;
    mon_clr <= 1'b1;
    @(posedge clock);
    mon_clr <= 1'b0;
  endtask : clr_mon
  task automatic run_row(input rlg_row_s r);
    bus_wr(rlg_pkg::ADDR_CTRL, 32'(r.ctrl));
    bus_wr(rlg_pkg::ADDR_EVENT, 32'h0000_00ff);
    clr_mon();
    if (r.op == 3'h6) bus_wr(rlg_pkg::ADDR_SHALLOW, 32'h0000_0000);
    else if (r.op == 3'h7) bus_wr(rlg_pkg::ADDR_DEEP, 32'(r.wd));
    else start_op(r.op, r.rail, r.len);
    wait_rel(rlg_pkg::DB_CYC_I + 4);
    check(32'(seen & r.chk), 32'(r.exp & r.chk));
    bus_rd(rlg_pkg::ADDR_CAUSE, d);
    if (r.exp[5]) check(d, 32'(r.cause));
    bus_rd(rlg_pkg::ADDR_EVENT, d);
    check(d, 32'(r.ev));
  endtask : run_row

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst_b, wr_stb, rd_stb, go, op, rail, len} = '0;
    {addr, wdata, err_total, cmp_count} = '0;
    mon_clr = 1'b1;
    rows = '{
      '{3'h0, 4'h0, 5'h00, 8'h00, 8'h1e, 6'h2d, 6'h24, 8'h01, 8'h01},
      '{3'h1, 4'h1, 5'h01, 8'h00, 8'h1e, 6'h2d, 6'h24, 8'h02, 8'h02},
      '{3'h1, 4'h2, 5'h02, 8'h00, 8'h1e, 6'h2d, 6'h24, 8'h02, 8'h02},
      '{3'h1, 4'h4, 5'h04, 8'h00, 8'h1e, 6'h2d, 6'h24, 8'h02, 8'h02},
      '{3'h1, 4'h8, 5'h08, 8'h00, 8'h1e, 6'h2d, 6'h24, 8'h02, 8'h02},
      '{3'h1, 4'h1, 5'h0e, 8'h00, 8'h1e, 6'h2d, 6'h00, 8'h00, 8'h00},
      '{3'h1, 4'h2, 5'h0d, 8'h00, 8'h1e, 6'h2d, 6'h00, 8'h00, 8'h00},
      '{3'h1, 4'h4, 5'h0b, 8'h00, 8'h1e, 6'h2d, 6'h00, 8'h00, 8'h00},
      '{3'h1, 4'h8, 5'h07, 8'h00, 8'h1e, 6'h2d, 6'h00, 8'h00, 8'h00},
      '{3'h2, 4'h0, 5'h00, 8'h00, 8'h01, 6'h3f, 6'h20, 8'h04, 8'h04},
      '{3'h6, 4'h0, 5'h00, 8'h00, 8'h00, 6'h3f, 6'h32, 8'h08, 8'h08},
      '{3'h7, 4'h0, 5'h00, 8'h1b, 8'h00, 6'h3f, 6'h3b, 8'h10, 8'h10},
      '{3'h7, 4'h0, 5'h00, 8'h1a, 8'h00, 6'h3f, 6'h00, 8'h00, 8'h00},
      '{3'h3, 4'h0, 5'h10, 8'h00, 8'h01, 6'h2d, 6'h20, 8'h20, 8'ha0},
      '{3'h3, 4'h0, 5'h00, 8'h00, 8'h01, 6'h2d, 6'h00, 8'h00, 8'h80},
      '{3'h4, 4'h0, 5'h00, 8'h00, 8'h1e, 6'h2d, 6'h20, 8'h40, 8'h40},
      '{3'h4, 4'h0, 5'h00, 8'h00, 8'h0a, 6'h20, 6'h00, 8'h00, 8'h00}
    };
    repeat (10) @(posedge clock);
    check(32'({system_reset_n, reset_pin_oe_b}), 32'h1);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    bus_wr(8'h24, 32'hffff_ffff);
    bus_rd(rlg_pkg::ADDR_CTRL, d);
    check(d, rlg_pkg::READ_ZERO);
    bus_rd(rlg_pkg::ADDR_MASK, d);
    check(d, rlg_pkg::READ_ZERO);
    bus_rd(8'h20, d);
    check(d, rlg_pkg::READ_ZERO);
    foreach (rows[i]) run_row(rows[i]);
    // Deeper request during a shallow reset restarts the hold
    bus_wr(rlg_pkg::ADDR_CTRL, 32'h0000_0000);
    clr_mon();
    bus_wr(rlg_pkg::ADDR_SHALLOW, 32'h0000_0000);
    repeat (20) @(posedge clock);
    bus_wr(rlg_pkg::ADDR_DEEP, 32'h0000_001b);
    wait_rel(4);
    check(32'(seen[3]), 32'h1);
    check(32'(lowcnt >= 8'(rlg_pkg::HOLD_CYC_I + 20) &&
              lowcnt <= 8'(rlg_pkg::HOLD_CYC_I + 25)), 32'h1);
    bus_rd(rlg_pkg::ADDR_CAUSE, d);
    check(d, 32'h0000_0018);
    // Interrupt raised, masked and cleared
    bus_wr(rlg_pkg::ADDR_MASK, 32'h0000_0004);
    bus_wr(rlg_pkg::ADDR_EVENT, 32'h0000_00ff);
    start_op(3'h2, 4'h0, 8'h01);
    wait_rel(4);
    check(32'(irq), 32'h1);
    bus_wr(rlg_pkg::ADDR_MASK, 32'h0000_0000);
    #1 check(32'(irq), 32'h0);
    @(posedge clock);
    bus_wr(rlg_pkg::ADDR_MASK, 32'h0000_0004);
    bus_wr(rlg_pkg::ADDR_EVENT, 32'h0000_0004);
    #1 check(32'(irq), 32'h0);
    @(posedge clock);
    // Unmasked watchdog interrupt without a reset
    bus_wr(rlg_pkg::ADDR_MASK, 32'h0000_0080);
    start_op(3'h3, 4'h0, 8'h01);
    @(posedge clock);
    check(32'(irq), 32'h1);
    check(32'(system_reset_n), 32'h1);
    // Retention from brown-out until power-down
    start_op(3'h0, 4'h0, 8'h1e);
    check(32'(rtc_on_rc_osc), 32'h1);
    wait_rel(4);
    check(32'({retain_hold, rtc_on_rc_osc}), 32'h2);
    start_op(3'h5, 4'h0, 8'h01);
    repeat (3) @(posedge clock);
    check(32'(retain_hold), 32'h0);
    end_sim();
  end
endmodule : reset_level_generator_tb_top
